// ### dsw_status.sv
/*
 * Drive status word composer, reference gate and actual value return.
 * Assumes all inputs synchronous to sys_clk; the adapter reads the word.
 */
// What this block does
// - bits 0-7 mirror drive state flags
// - bit 8 set when speed within tolerance
// - bit 9 set under remote external control
// - bit 10 set at or over limit
// - bit 11 high selects second external location
// - bits 11-12 valid only when routed to fieldbus
// - bit 12 shows external run permit
// - bits 13-14 pass drive-specific values through
// - bit 15 shows adapter communication error
// - reference is sign plus 15-bit magnitude
// - 0 to 20000 maps to full scale
// - actual values 16-bit, quantity chosen by actual_select input
// - fieldbus references used only when source configured
// - remote command low passes stop bits only
`timescale 1ns/1ns
`default_nettype none
module dsw_status
	import dsw_pkg::*;
#(
	parameter int SPEED_W = 16,
	parameter int ACT_SEL_W = 2
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rdy_on_flag,
	input wire logic rdy_oper_flag,
	input wire logic oper_enabled_flag,
	input wire logic fault_flag,
	input wire logic coast_stop_inactive_flag,
	input wire logic quick_stop_inactive_flag,
	input wire logic switch_on_inhibited_flag,
	input wire logic alarm_flag,
	input wire logic remote_control_active,
	input wire logic external_location_select,
	input wire logic external_run_permit_flag,
	input wire logic loc_routed_to_bus,
	input wire logic permit_routed_to_bus,
	input wire logic [1:0] drive_specific_bits,
	input wire logic adapter_comm_error_flag,
	input wire logic [SPEED_W-1:0] actual_speed,
	input wire logic [SPEED_W-1:0] nominal_speed,
	input wire logic [SPEED_W-1:0] speed_limit,
	input wire logic [`DSW_WORD_W-1:0] speed_reference_word,
	input wire logic [`DSW_WORD_W-1:0] master_control_word,
	input wire logic bus_is_ref_source,
	input wire logic [SPEED_W-1:0] speed_scale,
	input wire logic [ACT_SEL_W-1:0] actual_select,
	input wire logic [(1<<ACT_SEL_W)*`DSW_WORD_W-1:0] actual_sources,
	input wire logic status_read_strobe,
	input wire logic status_write_strobe,
	input wire logic [`DSW_WORD_W-1:0] status_write_data,
	output logic [`DSW_WORD_W-1:0] drive_state_word,
	output logic [`DSW_WORD_W-1:0] actual_value_word,
	output logic [`DSW_WORD_W-1:0] effective_control_word,
	output logic ref_valid,
	output logic ref_reverse,
	output logic [SPEED_W-1:0] ref_speed
);
	dsw_word_t status_q, status_d;
	dsw_word_t actual_q, actual_d;
	dsw_word_t ctrl_q, ctrl_d;
	logic ref_valid_q, ref_valid_d;
	logic [SPEED_W-1:0] speed_cmd;
	logic [SPEED_W-1:0] scaled_ref;
	logic dec_reverse;
	logic remote_cmd;

	// magnitude of a signed speed, so limits hold in both directions
	function automatic logic [SPEED_W-1:0] dsw_abs(input logic [SPEED_W-1:0] v);
		dsw_abs = v[SPEED_W-1] ? SPEED_W'(~v + SPEED_W'(1)) : v;
	endfunction : dsw_abs

	function automatic logic [SPEED_W+7:0] dsw_pct(
		input logic [SPEED_W-1:0] v, input logic [7:0] p);
		dsw_pct = (SPEED_W+8)'(v) * (SPEED_W+8)'(p);
	endfunction : dsw_pct

	dsw_ref_decode #(
		.SCALE_W(SPEED_W)
	) u_ref (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ref_word(speed_reference_word),
		.speed_scale(speed_scale),
		.ref_reverse(dec_reverse),
		.ref_scaled(scaled_ref)
	);

	assign remote_cmd = master_control_word[`DSW_CTRL_REMOTE_CMD];

	always_comb begin
		logic [SPEED_W-1:0] err;
		logic [SPEED_W-1:0] act_mag;
		logic [SPEED_W-1:0] cmd_mag;
		act_mag = dsw_abs(actual_speed);
		speed_cmd = dec_reverse ? SPEED_W'(~scaled_ref + SPEED_W'(1)) : scaled_ref;
		cmd_mag = scaled_ref;
		err = (act_mag > cmd_mag) ? SPEED_W'(act_mag - cmd_mag)
			: SPEED_W'(cmd_mag - act_mag);
		status_d = status_q;
		// writes from the master never reach the word
		if (status_read_strobe || !status_write_strobe) begin
			status_d = `DSW_WORD_ZERO;
			status_d[`DSW_BIT_RDY_ON] = rdy_on_flag;
			status_d[`DSW_BIT_RDY_OPER] = rdy_oper_flag;
			status_d[`DSW_BIT_OPER_EN] = oper_enabled_flag;
			status_d[`DSW_BIT_FAULT] = fault_flag;
			status_d[`DSW_BIT_COAST_INACT] = coast_stop_inactive_flag;
			status_d[`DSW_BIT_QUICK_INACT] = quick_stop_inactive_flag;
			status_d[`DSW_BIT_SWON_INHIB] = switch_on_inhibited_flag;
			status_d[`DSW_BIT_ALARM] = alarm_flag;
			status_d[`DSW_BIT_ON_TARGET] = (dsw_pct(err, 8'(`DSW_PERCENT_FULL))
				<= dsw_pct(nominal_speed, 8'(`DSW_TOL_PERCENT)));
			status_d[`DSW_BIT_REMOTE] = remote_control_active;
			status_d[`DSW_BIT_OVER_LIMIT] = (act_mag >= speed_limit);
			// unrouted bits read zero rather than stale drive state
			status_d[`DSW_BIT_EXT_LOC] =
				external_location_select & loc_routed_to_bus;
			status_d[`DSW_BIT_RUN_PERMIT] =
				external_run_permit_flag & permit_routed_to_bus;
			status_d[`DSW_BIT_SPEC_HI:`DSW_BIT_SPEC_LO] = drive_specific_bits;
			status_d[`DSW_BIT_COMM_ERR] = adapter_comm_error_flag;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `DSW_WORD_ZERO;
		end else begin
			status_q <= status_d;
		end
	end

	always_comb begin
		actual_d = actual_sources[actual_select*`DSW_WORD_W +: `DSW_WORD_W];
		// stop bits always pass; everything else needs remote command
		ctrl_d = remote_cmd ? master_control_word
			: (master_control_word & `DSW_CTRL_STOP_MASK);
		ref_valid_d = bus_is_ref_source & remote_cmd;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			actual_q <= `DSW_WORD_ZERO;
			ctrl_q <= `DSW_WORD_ZERO;
			ref_valid_q <= 1'b0;
		end else begin
			actual_q <= actual_d;
			ctrl_q <= ctrl_d;
			ref_valid_q <= ref_valid_d;
		end
	end

	assign drive_state_word = status_q;
	assign actual_value_word = actual_q;
	assign effective_control_word = ctrl_q;
	assign ref_valid = ref_valid_q;
	assign ref_reverse = ref_valid_q & dec_reverse;
	assign ref_speed = ref_valid_q ? speed_cmd : '0;

	a_fault_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !status_write_strobe
		|=> drive_state_word[`DSW_BIT_FAULT] == $past(fault_flag))
		else $error("fault bit mismatch");

	a_ready_on_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_RDY_ON] == $past(rdy_on_flag))
		else $error("ready on bit wrong");

	a_ready_oper_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_RDY_OPER] == $past(rdy_oper_flag))
		else $error("ready oper bit wrong");

	a_oper_en_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_OPER_EN] == $past(oper_enabled_flag))
		else $error("oper enabled bit wrong");

	a_coast_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_COAST_INACT]
		== $past(coast_stop_inactive_flag))
		else $error("coast stop bit wrong");

	a_quick_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_QUICK_INACT]
		== $past(quick_stop_inactive_flag))
		else $error("quick stop bit wrong");

	a_inhibit_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_SWON_INHIB]
		== $past(switch_on_inhibited_flag))
		else $error("inhibit bit wrong");

	a_alarm_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_ALARM] == $past(alarm_flag))
		else $error("alarm bit wrong");

	// exact match must always count as on target
	a_target_hit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		&& dsw_abs(actual_speed) == scaled_ref
		|=> drive_state_word[`DSW_BIT_ON_TARGET])
		else $error("on target bit missed");

	// error above full nominal speed is far outside tolerance
	a_target_miss: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		&& {1'b0, dsw_abs(actual_speed)}
		> {1'b0, scaled_ref} + {1'b0, nominal_speed}
		|=> !drive_state_word[`DSW_BIT_ON_TARGET])
		else $error("on target bit false");

	a_remote_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_REMOTE] == $past(remote_control_active))
		else $error("remote bit wrong");

	a_over_limit_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_OVER_LIMIT]
		== $past(dsw_abs(actual_speed) >= speed_limit))
		else $error("over limit bit wrong");

	a_loc_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) loc_routed_to_bus && status_read_strobe
		|=> drive_state_word[`DSW_BIT_EXT_LOC]
		== $past(external_location_select))
		else $error("location bit wrong");

	a_loc_first: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !external_location_select && status_read_strobe
		|=> !drive_state_word[`DSW_BIT_EXT_LOC])
		else $error("first location not low");

	a_loc_gated: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !loc_routed_to_bus && status_read_strobe
		|=> !drive_state_word[`DSW_BIT_EXT_LOC])
		else $error("loc ungated");

	a_permit_gated: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !permit_routed_to_bus && status_read_strobe
		|=> !drive_state_word[`DSW_BIT_RUN_PERMIT])
		else $error("permit ungated");

	a_permit_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) permit_routed_to_bus && status_read_strobe
		|=> drive_state_word[`DSW_BIT_RUN_PERMIT]
		== $past(external_run_permit_flag))
		else $error("permit bit wrong");

	a_permit_absent: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !external_run_permit_flag && status_read_strobe
		|=> !drive_state_word[`DSW_BIT_RUN_PERMIT])
		else $error("permit bit without signal");

	a_spec_pass: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_SPEC_HI:`DSW_BIT_SPEC_LO]
		== $past(drive_specific_bits))
		else $error("spec bits wrong");

	a_comm_err_bit: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_read_strobe
		|=> drive_state_word[`DSW_BIT_COMM_ERR]
		== $past(adapter_comm_error_flag))
		else $error("comm err bit");

	a_sign_reverse: assert property (@(posedge sys_clk)
		disable iff (!rst_n) 1'b1
		|=> dec_reverse == $past(speed_reference_word[`DSW_SIGN_BIT]))
		else $error("sign bit not decoded");

	a_full_scale: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		speed_reference_word == `DSW_WORD_W'(`DSW_REF_FULL_SCALE)
		|=> scaled_ref == $past(speed_scale))
		else $error("full scale reference wrong");

	a_zero_ref: assert property (@(posedge sys_clk)
		disable iff (!rst_n) speed_reference_word == `DSW_WORD_ZERO
		|=> scaled_ref == '0)
		else $error("zero reference not zero");

	a_actual_sel: assert property (@(posedge sys_clk)
		disable iff (!rst_n) 1'b1
		|=> actual_value_word == $past(actual_sources[actual_select
		*`DSW_WORD_W +: `DSW_WORD_W]))
		else $error("actual mux wrong");

	a_ref_gate: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !(bus_is_ref_source && remote_cmd)
		|=> ref_speed == '0)
		else $error("reference leaked");

	a_ref_valid: assert property (@(posedge sys_clk)
		disable iff (!rst_n) 1'b1
		|=> ref_valid == $past(bus_is_ref_source && remote_cmd))
		else $error("reference valid wrong");

	a_reverse_gated: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !ref_valid |-> !ref_reverse)
		else $error("reverse without valid");

	a_speed_fwd: assert property (@(posedge sys_clk)
		disable iff (!rst_n) ref_valid && !dec_reverse
		|-> ref_speed == scaled_ref)
		else $error("forward speed wrong");

	a_stop_only: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !remote_cmd
		|=> (effective_control_word & ~`DSW_CTRL_STOP_MASK) == '0)
		else $error("control passed without remote");

	a_stop_pass: assert property (@(posedge sys_clk)
		disable iff (!rst_n) 1'b1
		|=> (effective_control_word & `DSW_CTRL_STOP_MASK)
		== ($past(master_control_word) & `DSW_CTRL_STOP_MASK))
		else $error("stop bits blocked");

	a_remote_pass: assert property (@(posedge sys_clk)
		disable iff (!rst_n) remote_cmd
		|=> effective_control_word == $past(master_control_word))
		else $error("remote control word blocked");

	a_write_ignored: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_write_strobe && !status_read_strobe
		|=> $stable(drive_state_word))
		else $error("status write took effect");

	a_read_wins: assert property (@(posedge sys_clk)
		disable iff (!rst_n) status_write_strobe && status_read_strobe
		|=> drive_state_word[`DSW_BIT_FAULT] == $past(fault_flag))
		else $error("read with write not refreshed");
endmodule : dsw_status
`default_nettype wire

// ### dsw_params.svh
/*
 * Constants of the drive status word profile: bit positions, widths, scaling.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef DSW_PARAMS_SVH
`define DSW_PARAMS_SVH

`define DSW_WORD_W 16
`define DSW_MAG_W 15
`define DSW_SIGN_BIT 15
`define DSW_BIT_RDY_ON 0
`define DSW_BIT_RDY_OPER 1
`define DSW_BIT_OPER_EN 2
`define DSW_BIT_FAULT 3
`define DSW_BIT_COAST_INACT 4
`define DSW_BIT_QUICK_INACT 5
`define DSW_BIT_SWON_INHIB 6
`define DSW_BIT_ALARM 7
`define DSW_BIT_ON_TARGET 8
`define DSW_BIT_REMOTE 9
`define DSW_BIT_OVER_LIMIT 10
`define DSW_BIT_EXT_LOC 11
`define DSW_BIT_RUN_PERMIT 12
`define DSW_BIT_SPEC_LO 13
`define DSW_BIT_SPEC_HI 14
`define DSW_BIT_COMM_ERR 15
`define DSW_TOL_PERCENT 10
`define DSW_PERCENT_FULL 100
`define DSW_REF_FULL_SCALE 20000
`define DSW_CTRL_REMOTE_CMD 10
`define DSW_CTRL_STOP_MASK 16'h0007
`define DSW_WORD_ZERO 16'h0000

`endif

// ### dsw_pkg.sv
/*
 * Types shared by the drive status word profile modules.
 * Assumes dsw_params.svh is reachable on the include path.
 */
`include "dsw_params.svh"
package dsw_pkg;
	typedef logic [`DSW_WORD_W-1:0] dsw_word_t;
	typedef logic [`DSW_MAG_W-1:0] dsw_mag_t;
endpackage : dsw_pkg

// ### dsw_ref_decode.sv
/*
 * Decodes a signed fieldbus reference: sign and 15-bit magnitude, scaled
 * onto the speed scaling value. Assumes one clock, async active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module dsw_ref_decode
	import dsw_pkg::*;
#(
	parameter int SCALE_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [`DSW_WORD_W-1:0] ref_word,
	input wire logic [SCALE_W-1:0] speed_scale,
	output logic ref_reverse,
	output logic [SCALE_W-1:0] ref_scaled
);
	logic [SCALE_W-1:0] ref_scaled_d;
	logic ref_reverse_d;
	logic [`DSW_MAG_W-1:0] mag;
	logic [`DSW_WORD_W-1:0] neg;
	logic [SCALE_W+`DSW_MAG_W-1:0] prod;

	always_comb begin
		ref_reverse_d = ref_word[`DSW_SIGN_BIT];
		// reversed direction arrives as two's complement of the positive
		neg = (~ref_word) + `DSW_WORD_W'(1);
		mag = ref_reverse_d ? neg[`DSW_MAG_W-1:0] : ref_word[`DSW_MAG_W-1:0];
		prod = (SCALE_W+`DSW_MAG_W)'(mag) * (SCALE_W+`DSW_MAG_W)'(speed_scale);
		// full scale 20000 maps to 100 percent of the scaling value
		ref_scaled_d = SCALE_W'(prod / (SCALE_W+`DSW_MAG_W)'(`DSW_REF_FULL_SCALE));
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_reverse <= 1'b0;
			ref_scaled <= '0;
		end else begin
			ref_reverse <= ref_reverse_d;
			ref_scaled <= ref_scaled_d;
		end
	end
endmodule : dsw_ref_decode
`default_nettype wire

// ### dsw_master_model.sv
/*
 * Fieldbus master model: encodes signed references, sends the control
 * word and issues read/write strobes. Assumes the bench sets the
 * commands at the rising edge; everything is registered one cycle here.
 */
`timescale 1ns/1ns
`default_nettype none
module dsw_master_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [14:0] cmd_mag,
	input wire logic cmd_rev,
	input wire logic [15:0] cmd_ctrl,
	input wire logic cmd_rd,
	input wire logic cmd_wr,
	output logic [15:0] ref_word,
	output logic [15:0] ctrl_word,
	output logic rd_stb,
	output logic wr_stb
);
	logic [15:0] pos;
	assign pos = {1'b0, cmd_mag};
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_word <= 16'h0000;
			ctrl_word <= 16'h0000;
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
		end else begin
			// reverse sent as two's complement of the positive word
			ref_word <= cmd_rev ? 16'h0000 - pos : pos;
			ctrl_word <= cmd_ctrl;
			rd_stb <= cmd_rd;
			wr_stb <= cmd_wr;
		end
	end
endmodule : dsw_master_model
`default_nettype wire

// ### dsw_status_bench.sv
/*
 * Self-checking bench for the status word composer and reference gate.
 * Assumes dsw_pkg and dsw_master_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module dsw_status_bench;
	import dsw_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] st = 8'h00;
	logic rem = 1'b0, loc = 1'b0, prm = 1'b0, rl = 1'b0, rp = 1'b0;
	logic err = 1'b0, src = 1'b0, rev = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [1:0] spec = 2'h0, sel = 2'h0;
	logic [15:0] act = 16'h0000, nom = 16'h0000, lim = 16'h0000;
	logic [15:0] scl = 16'h0000, ctl = 16'h0000, wdat = 16'h0000;
	logic [63:0] srcs = 64'h0;
	logic [14:0] mag = 15'h0000;
	dsw_word_t word, av, ecw, mref, mctl, old;
	logic rv, rr, rds, wrs;
	logic [15:0] rs;
	int fail_count = 0;
	int checks_done = 0;
	always #5 sys_clk = ~sys_clk;
	dsw_master_model u_dsw_master_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.cmd_mag(mag), .cmd_rev(rev), .cmd_ctrl(ctl), .cmd_rd(rd),
		.cmd_wr(wr), .ref_word(mref), .ctrl_word(mctl), .rd_stb(rds),
		.wr_stb(wrs));
	dsw_status u_dsw_status (.sys_clk(sys_clk), .rst_n(rst_n),
		.rdy_on_flag(st[0]), .rdy_oper_flag(st[1]),
		.oper_enabled_flag(st[2]), .fault_flag(st[3]),
		.coast_stop_inactive_flag(st[4]), .quick_stop_inactive_flag(st[5]),
		.switch_on_inhibited_flag(st[6]), .alarm_flag(st[7]),
		.remote_control_active(rem), .external_location_select(loc),
		.external_run_permit_flag(prm), .loc_routed_to_bus(rl),
		.permit_routed_to_bus(rp), .drive_specific_bits(spec),
		.adapter_comm_error_flag(err), .actual_speed(act),
		.nominal_speed(nom), .speed_limit(lim), .speed_reference_word(mref),
		.master_control_word(mctl), .bus_is_ref_source(src),
		.speed_scale(scl), .actual_select(sel), .actual_sources(srcs),
		.status_read_strobe(rds), .status_write_strobe(wrs),
		.status_write_data(wdat), .drive_state_word(word),
		.actual_value_word(av), .effective_control_word(ecw),
		.ref_valid(rv), .ref_reverse(rr), .ref_speed(rs));
	task automatic close_out();
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	function automatic dsw_word_t exp_word();
		longint d;
		logic on, ov;
		d = longint'($signed(act)) - longint'(scl);
		if (d < 0) d = -d;
		on = d * 100 <= longint'(nom) * 10;
		d = longint'($signed(act));
		if (d < 0) d = -d;
		ov = d >= longint'(lim);
		return {err, spec, prm & rp, loc & rl, ov, rem, on, st};
	endfunction : exp_word
	function automatic logic [15:0] exp_ref(logic v);
		logic [15:0] m;
		m = 16'(longint'(mag) * longint'(scl) / 20000);
		if (!v) return 16'h0000;
		return rev ? 16'h0000 - m : m;
	endfunction : exp_ref
	task automatic ref_case(int i);
		logic v;
		@(posedge sys_clk);
		mag <= 15'((i % 3) * 10000);
		rev <= 1'($urandom);
		src <= 1'(i / 6);
		ctl <= (16'($urandom) & 16'hFBFF) | 16'(((i / 3) % 2) << 10);
		scl <= 16'(4 * $urandom_range(1, 8000));
		repeat (4) @(posedge sys_clk);
		#1;
		v = ctl[10] & src;
		chk("ref_valid", 16'(rv), 16'(v));
		chk("ref_speed", rs, exp_ref(v));
		chk("ref_reverse", 16'(rr), 16'(v & rev & (mag != 0)));
		chk("ctrl_word", ecw, ctl[10] ? ctl : ctl & 16'h0007);
	endtask : ref_case
	task automatic stat_case();
		int s;
		s = $urandom_range(2000, 30000);
		@(posedge sys_clk);
		{st, rem, loc, prm, rl, rp, err, spec} <= 16'($urandom);
		scl <= 16'(s);
		act <= 16'(s + $urandom_range(0, 4000) - 2000);
		nom <= 16'($urandom_range(0, 40000));
		lim <= 16'($urandom);
		mag <= 15'd20000;
		rev <= 1'($urandom);
		src <= 1'b1;
		ctl <= 16'h0400 | 16'($urandom);
		sel <= 2'($urandom);
		srcs <= {$urandom, $urandom};
		wdat <= 16'($urandom);
		repeat (4) @(posedge sys_clk);
		#1;
		chk("state_word", word, exp_word());
		chk("actual", av, srcs[sel * 16 +: 16]);
	endtask : stat_case
	initial begin
		#100000;
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(11255));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd <= 1'b1;
		for (int i = 0; i < 12; i++) ref_case(i);
		for (int i = 0; i < 40; i++) begin
			stat_case();
			// write-only cycle must leave the word untouched
			old = exp_word();
			wr <= 1'b1;
			rd <= 1'b0;
			@(posedge sys_clk);
			st <= ~st;
			wr <= 1'b0;
			rd <= 1'b1;
			@(posedge sys_clk);
			#1;
			chk("held_word", word, old);
			@(posedge sys_clk);
			#1;
			chk("fresh_word", word, exp_word());
		end
		close_out();
	end
endmodule : dsw_status_bench
`default_nettype wire
